// ==== include/ocp_defs.svh ====
/*
 * timing and encoding constants for the overcurrent protection controller.
 * assumes a 25 MHz device clock.
 */
`ifndef OCP_DEFS_SVH
`define OCP_DEFS_SVH

`define OCP_CLK_HZ          25000000
`define OCP_DELAY_MS        10
`define OCP_DELAY_CYCLES    ((`OCP_DELAY_MS * `OCP_CLK_HZ) / 1000)
`define OCP_CNT_W           24
`define OCP_THR_W           2
`define OCP_THR_RESET       2'h0
`define OCP_CNT_ZERO        24'h000000
`define OCP_CNT_ONE         24'h000001

`endif

// ==== include/ocp_pkg.sv ====
/*
 * types shared by the overcurrent protection controller.
 * assumes ocp_defs.svh is included first.
 */
package ocp_pkg;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_DETECT,
		ST_PROBE,
		ST_RELEASE
	} ocp_state_e;

	typedef struct packed {
		logic discharge_switch_ctrl_bit;
		logic charge_switch_ctrl_bit;
	} switch_ctrl_s;

	typedef struct packed {
		logic discharge_switch_drive;
		logic charge_switch_drive;
		logic load_probe_current;
	} switch_out_s;

endpackage

// ==== hdl/ocp_fsm.sv ====
/*
 * overcurrent protection state machine: detect delay, switch cut, load
 * probe, release delay and switch restore.
 * assumes comparator outputs from the analog front end pass a two-flop synchronizer here, and control bits
 * written by the microcontroller arrive as plain levels on this clock.
 */
`timescale 1ns/1ps
`include "ocp_defs.svh"

module ocp_fsm
	import ocp_pkg::*;
#(
	parameter logic [`OCP_CNT_W-1:0] DELAY_CYCLES =
		`OCP_CNT_W'(`OCP_DELAY_CYCLES)
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_sense_above_thr,
	input  wire logic                  i_load_above_release,
	input  wire switch_ctrl_s          i_ctrl,
	input  wire logic                  i_config_write_cmd,
	input  wire logic [`OCP_THR_W-1:0] i_threshold_sel,
	output logic [`OCP_THR_W-1:0]      o_overcurrent_threshold,
	output switch_out_s                o_sw,
	output logic                       o_regulated_output_en,
	output logic                       o_protect_active
);

	ocp_state_e              state;
	logic [1:0]              sense_sync;
	logic [1:0]              load_sync;
	logic                    sense_hi;
	logic                    load_hi;
	logic [`OCP_CNT_W-1:0]   count;
	logic                    count_done;
	logic                    dis_changed;
	logic                    dis_at_entry;
	logic                    in_prot;
	logic                    dis_drive;
	logic                    chg_drive;
	logic                    probe_on;

	assign sense_hi   = sense_sync[1];
	assign load_hi    = load_sync[1];
	assign count_done = (count >= DELAY_CYCLES - `OCP_CNT_ONE);
	assign in_prot    = (state == ST_PROBE) || (state == ST_RELEASE);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sense_sync <= 2'h0;
			load_sync  <= 2'h0;
		end else begin
			sense_sync <= {sense_sync[0], i_sense_above_thr};
			load_sync  <= {load_sync[0], i_load_above_release};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_overcurrent_threshold <= `OCP_THR_RESET;
		else if (i_config_write_cmd)
			o_overcurrent_threshold <= i_threshold_sel;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_NORMAL;
		end else begin
			case (state)
			ST_NORMAL: begin
				if (sense_hi)
					state <= ST_DETECT;
			end
			ST_DETECT: begin
				if (!sense_hi)
					state <= ST_NORMAL;
				else if (count_done)
					state <= ST_PROBE;
			end
			ST_PROBE: begin
				if (load_hi)
					state <= ST_RELEASE;
			end
			ST_RELEASE: begin
				if (count_done && !sense_hi)
					state <= ST_NORMAL;
			end
			default: state <= ST_NORMAL;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			count <= `OCP_CNT_ZERO;
		else if ((state == ST_DETECT && sense_hi && !count_done) ||
			 (state == ST_RELEASE && !count_done))
			count <= count + `OCP_CNT_ONE;
		else if (state == ST_RELEASE)
			count <= count;
		else
			count <= `OCP_CNT_ZERO;
	end

	// watch discharge control bit during protection
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dis_at_entry <= 1'b1;
			dis_changed  <= 1'b0;
		end else if (state == ST_DETECT && sense_hi && count_done) begin
			dis_at_entry <= i_ctrl.discharge_switch_ctrl_bit;
			dis_changed  <= 1'b0;
		end else if (in_prot &&
			     i_ctrl.discharge_switch_ctrl_bit != dis_at_entry) begin
			dis_changed <= 1'b1;
		end
	end

	// discharge switch drive, high is off
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dis_drive <= 1'b0;
		end else if (state == ST_DETECT && sense_hi && count_done) begin
			dis_drive <= 1'b1;
		end else if (state == ST_RELEASE && count_done && !sense_hi) begin
			dis_drive <=
				dis_changed ? !i_ctrl.discharge_switch_ctrl_bit : 1'b0;
		end else if (!in_prot) begin
			dis_drive <= !i_ctrl.discharge_switch_ctrl_bit;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			chg_drive <= 1'b0;
		else if (!in_prot)
			chg_drive <= !i_ctrl.charge_switch_ctrl_bit;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			probe_on <= 1'b0;
		else
			probe_on <=
				(state == ST_DETECT && sense_hi && count_done) ||
				(state == ST_PROBE && !load_hi);
	end

	// switch outputs gathered from their own flops
	assign o_sw = '{
		discharge_switch_drive: dis_drive,
		charge_switch_drive:    chg_drive,
		load_probe_current:     probe_on
	};

	assign o_regulated_output_en = 1'b1;
	assign o_protect_active      = in_prot;

	property p_entry_cuts;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_DETECT && sense_hi && count_done) |=>
			(o_sw.discharge_switch_drive && o_sw.load_probe_current &&
			 state == ST_PROBE);
	endproperty
	a_entry_cuts: assert property (p_entry_cuts)
		else $error("discharge switch not cut on entry");

	property p_reg_on;
		@(posedge i_clk) disable iff (!i_rst_n)
		in_prot |-> o_regulated_output_en;
	endproperty
	a_reg_on: assert property (p_reg_on)
		else $error("regulator off in protection");

	property p_probe_on;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_PROBE && !load_hi && $past(state) == ST_PROBE)
			|-> o_sw.load_probe_current;
	endproperty
	a_probe_on: assert property (p_probe_on)
		else $error("probe current missing");

	property p_detect_start;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_NORMAL && sense_hi) |=>
			(state == ST_DETECT && !o_protect_active);
	endproperty
	a_detect_start: assert property (p_detect_start)
		else $error("detect timer not started");

	property p_abort;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_DETECT && !sense_hi) |=>
			(state == ST_NORMAL && count == `OCP_CNT_ZERO);
	endproperty
	a_abort: assert property (p_abort)
		else $error("detect not aborted");

	sequence s_frozen;
		in_prot ##1 in_prot;
	endsequence
	property p_frozen;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_frozen |-> $stable(o_sw.charge_switch_drive);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("charge pin moved in protection");

	property p_release_start;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_PROBE && load_hi) |=>
			(state == ST_RELEASE && !o_sw.load_probe_current);
	endproperty
	a_release_start: assert property (p_release_start)
		else $error("release timer not started");

	property p_exit;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_RELEASE && count_done && !sense_hi && !dis_changed)
			|=> (state == ST_NORMAL && !o_sw.discharge_switch_drive);
	endproperty
	a_exit: assert property (p_exit)
		else $error("discharge switch not restored");

	property p_cfg;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_config_write_cmd |=>
			(o_overcurrent_threshold == $past(i_threshold_sel));
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("threshold not applied");

endmodule

// ==== test/pack_load_model.sv ====
/*
 * pack load and switch model for the protection fsm bench.
 * assumes the bench commands an overload as a plain level.
 */
`timescale 1ns/1ps
module pack_load_model
	import ocp_pkg::*;
(
	input  wire logic        i_overload,
	input  wire switch_out_s i_sw,
	output logic             o_sense_above_thr,
	output logic             o_load_above_release
);
	// aux gate off, no bypass path
	// current flows only while discharge switch on
	assign o_sense_above_thr = i_overload & ~i_sw.discharge_switch_drive;
	// probe reads high resistance once load gone
	assign o_load_above_release = i_sw.load_probe_current & ~i_overload;
endmodule

// ==== test/ocp_fsm_bench.sv ====
/*
 * self-checking bench for the overcurrent protection fsm.
 * assumes ocp_pkg is compiled first; delay shortened to 8 cycles.
 */
`timescale 1ns/1ps
module ocp_fsm_bench
	import ocp_pkg::*;
;
	localparam int D = 8;
	logic         i_clk = 1'b0;
	logic         i_rst_n = 1'b0;
	logic         overload = 1'b0;
	logic         sense;
	logic         load_hi;
	switch_ctrl_s ctrl = 2'h3;
	logic         cfg_cmd = 1'b0;
	logic [1:0]   thr_sel = 2'h0;
	logic [1:0]   thr;
	switch_out_s  sw;
	logic         reg_en;
	logic         prot;
	int           num_errors = 0;
	int           check_count = 0;

	ocp_fsm #(.DELAY_CYCLES(D)) u_dut (
		.i_clk                   (i_clk),
		.i_rst_n                 (i_rst_n),
		.i_sense_above_thr       (sense),
		.i_load_above_release    (load_hi),
		.i_ctrl                  (ctrl),
		.i_config_write_cmd      (cfg_cmd),
		.i_threshold_sel         (thr_sel),
		.o_overcurrent_threshold (thr),
		.o_sw                    (sw),
		.o_regulated_output_en   (reg_en),
		.o_protect_active        (prot)
	);

	pack_load_model u_load (
		.i_overload           (overload),
		.i_sw                 (sw),
		.o_sense_above_thr    (sense),
		.o_load_above_release (load_hi)
	);

	initial begin
		forever #20 i_clk = ~i_clk;
	end

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// which 1 waits on probe, else on protect flag
	task automatic wait_until(input logic which, input logic v);
		int n;
		n = 0;
		while ((which ? sw.load_probe_current : prot) !== v) begin
			@(negedge i_clk);
			n++;
			if (n > 100) begin
				chk(4'h0, 4'h1);
				end_sim();
			end
		end
	endtask

	task automatic t_normal();
		chk({1'b0, sw}, 4'h0);
		chk({3'h0, reg_en}, 4'h1);
	endtask

	task automatic t_thr();
		for (int i = 0; i < 4; i++) begin
			thr_sel = 2'(i);
			cfg_cmd = 1'b1;
			@(negedge i_clk);
			cfg_cmd = 1'b0;
			@(negedge i_clk);
			chk({2'h0, thr}, 4'(i));
		end
		thr_sel = 2'h1;
		repeat (3) @(negedge i_clk);
		chk({2'h0, thr}, 4'h3);
	endtask

	task automatic t_glitch();
		overload = 1'b1;
		repeat (D - 2) @(negedge i_clk);
		overload = 1'b0;
		repeat (D + 4) @(negedge i_clk);
		chk({3'h0, prot}, 4'h0);
		chk({1'b0, sw}, 4'h0);
	endtask

	task automatic t_trip(input logic flip);
		overload = 1'b1;
		repeat (D + 2) @(negedge i_clk);
		chk({3'h0, prot}, 4'h0);
		@(negedge i_clk);
		chk({3'h0, prot}, 4'h1);
		wait_until(1'b0, 1'b1);
		chk({1'b0, sw}, 4'h5);
		chk({3'h0, reg_en}, 4'h1);
		ctrl.charge_switch_ctrl_bit = 1'b0;
		ctrl.discharge_switch_ctrl_bit = ~flip;
		repeat (3) @(negedge i_clk);
		chk({1'b0, sw}, 4'h5);
		ctrl.charge_switch_ctrl_bit = 1'b1;
		overload = 1'b0;
		wait_until(1'b1, 1'b0);
		chk({3'h0, prot}, 4'h1);
		chk({3'h0, sw.discharge_switch_drive}, 4'h1);
		repeat (D - 1) @(negedge i_clk);
		chk({3'h0, prot}, 4'h1);
		wait_until(1'b0, 1'b0);
		@(negedge i_clk);
		chk({1'b0, sw}, {1'b0, flip, 2'h0});
		ctrl = 2'h3;
		repeat (3) @(negedge i_clk);
		chk({1'b0, sw}, 4'h0);
	endtask

	initial begin
		repeat (20) @(negedge i_clk);
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_clk);
		t_normal();
		t_thr();
		t_glitch();
		t_trip(1'b0);
		t_trip(1'b1);
		end_sim();
	end
endmodule
